/* design/rsc_reset_ctrl.sv */
/*
  reset source controller: merges power-on, hard-line, watchdog, bus monitor
  and tap sources into power-on, hard and soft flows, with an avalon-mm slave.
  assumes all inputs synchronous to sys_clk, which is also the input clock,
  and an outside wire that resolves the open-drain hard-reset line.
*/
`timescale 1ns/1ps
`include "rsc_cfg.svh"
module rsc_reset_ctrl #(
  parameter int CNT_W = 16,
  parameter int POR_RELEASE = `RSC_POR_RELEASE_CLKS * `RSC_CLKS_PER_INPUT_CLK,
  parameter int HARD_HOLD = `RSC_HARD_HOLD_CLKS * `RSC_CLKS_PER_INPUT_CLK,
  parameter int SOFT_HOLD = `RSC_SOFT_HOLD_CLKS * `RSC_CLKS_PER_INPUT_CLK
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // board reset pins
  input wire logic power_on_reset_in_n,
  input wire logic hard_reset_line_in_n,
  output logic hard_reset_line_out,
  output logic hard_reset_line_oe,
  // internal sources
  input wire logic watchdog_zero,
  input wire logic bus_monitor_zero,
  input wire logic tap_extest,
  input wire logic tap_clamp,
  input wire logic tap_highz,
  // straps
  input wire logic [1:0] boot_mode_strap,
  input wire logic watchdog_enable_strap,
  input wire logic host_byte_width_strap,
  input wire logic host_strobe_strap,
  // reset outputs
  output rsc_pkg::rsc_rst_s rst_out,
  output logic soft_reset_internal,
  output rsc_pkg::rsc_strap_s strap_out,
  output logic config_from_host,
  // avalon-mm slave
  input wire logic [`RSC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt
  output logic irq
);
  import rsc_pkg::*;

  // refuse counts the counter cannot hold
  initial begin
    if (POR_RELEASE < 1 || HARD_HOLD < 1 || SOFT_HOLD < 1 || POR_RELEASE >= 2**CNT_W ||
        HARD_HOLD >= 2**CNT_W || SOFT_HOLD >= 2**CNT_W) begin
      $error("rsc_reset_ctrl: count out of range");
    end
  end

  localparam logic [CNT_W-1:0] POR_CNT = CNT_W'(POR_RELEASE);
  localparam logic [CNT_W-1:0] HARD_CNT = CNT_W'(HARD_HOLD);
  localparam logic [CNT_W-1:0] SOFT_CNT = CNT_W'(SOFT_HOLD);

  rsc_state_e state_ff;
  rsc_state_e nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [1:0] ctrl_ff;
  rsc_src_t src_ff;
  rsc_src_t istat_ff;
  rsc_src_t imask_ff;
  rsc_strap_s strap_ff;
  logic por_seen_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  rsc_src_t req;
  logic hard_req;
  logic soft_req;
  logic flow_start;
  logic por_rise;
  logic acc_ok;
  logic sel_ctrl;
  logic sel_src;
  logic sel_strap;
  logic sel_istat;
  logic sel_imask;
  logic istat_clr;
  logic [31:0] nxt_rdata;

  // source requests; the line is only read while we are not pulling it
  always_comb begin
    req = '0;
    req[`RSC_SRC_POR] = ~power_on_reset_in_n;
    req[`RSC_SRC_HARD_EXT] = ~hard_reset_line_in_n & ~hard_reset_line_oe;
    req[`RSC_SRC_WDOG] = watchdog_zero & ctrl_ff[`RSC_CTRL_WDOG_EN];
    req[`RSC_SRC_BMON] = bus_monitor_zero & ctrl_ff[`RSC_CTRL_BMON_EN];
    req[`RSC_SRC_TAP] = tap_extest | tap_clamp | tap_highz;
  end
  assign hard_req = req[`RSC_SRC_HARD_EXT] | req[`RSC_SRC_WDOG] | req[`RSC_SRC_BMON];
  assign soft_req = req[`RSC_SRC_TAP];

  // flow selection, widest flow wins
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    flow_start = 1'b0;
    if (req[`RSC_SRC_POR]) begin
      nxt_state = RSC_ST_POR;
      nxt_cnt = POR_CNT;
      flow_start = (state_ff != RSC_ST_POR);
    end else begin
      case (state_ff)
        RSC_ST_POR: begin
          // count from the release edge of power-on reset
          if (cnt_ff == CNT_W'(1)) begin
            nxt_state = RSC_ST_RUN;
          end else begin
            nxt_cnt = cnt_ff - CNT_W'(1);
          end
        end
        RSC_ST_HARD: begin
          if (cnt_ff == CNT_W'(1)) begin
            nxt_state = RSC_ST_RUN;
          end else begin
            nxt_cnt = cnt_ff - CNT_W'(1);
          end
        end
        RSC_ST_SOFT: begin
          if (hard_req) begin
            nxt_state = RSC_ST_HARD;
            nxt_cnt = HARD_CNT;
            flow_start = 1'b1;
          end else if (cnt_ff == CNT_W'(1)) begin
            nxt_state = RSC_ST_RUN;
          end else begin
            nxt_cnt = cnt_ff - CNT_W'(1);
          end
        end
        default: begin
          if (hard_req) begin
            nxt_state = RSC_ST_HARD;
            nxt_cnt = HARD_CNT;
            flow_start = 1'b1;
          end else if (soft_req) begin
            nxt_state = RSC_ST_SOFT;
            nxt_cnt = SOFT_CNT;
            flow_start = 1'b1;
          end
        end
      endcase
    end
  end

  // flow state and counter
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_ff <= RSC_ST_POR;
      cnt_ff <= POR_CNT;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // reset outputs decoded from the flow state
  always_comb begin
    rst_out.pll = (state_ff == RSC_ST_POR);
    rst_out.core = (state_ff != RSC_ST_RUN);
    rst_out.periph = (state_ff != RSC_ST_RUN);
    rst_out.timer = (state_ff != RSC_ST_RUN);
    rst_out.clk_stop = (state_ff != RSC_ST_RUN);
  end
  assign soft_reset_internal = (state_ff == RSC_ST_SOFT);
  // open drain: only ever pulls low
  assign hard_reset_line_out = 1'b0;
  assign hard_reset_line_oe = (state_ff == RSC_ST_POR) || (state_ff == RSC_ST_HARD);

  // strap capture on power-on release only
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      por_seen_ff <= 1'b0;
    end else begin
      por_seen_ff <= power_on_reset_in_n;
    end
  end
  assign por_rise = power_on_reset_in_n & ~por_seen_ff;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      strap_ff <= '0;
    end else if (por_rise) begin
      strap_ff.boot_mode <= boot_mode_strap;
      strap_ff.watchdog_en <= watchdog_enable_strap;
      strap_ff.host_byte_width <= host_byte_width_strap;
      strap_ff.host_strobe <= host_strobe_strap;
    end
  end
  assign strap_out = strap_ff;
  // boot mode 0 loads configuration from the host port, else from i2c memory
  assign config_from_host = (strap_ff.boot_mode == 2'h0);

  // address decode, one select per register; unmapped offsets select nothing
  always_comb begin
    sel_ctrl = 1'b0;
    sel_src = 1'b0;
    sel_strap = 1'b0;
    sel_istat = 1'b0;
    sel_imask = 1'b0;
    if (avs_address == `RSC_OFS_CTRL) begin
      sel_ctrl = 1'b1;
    end else if (avs_address == `RSC_OFS_SRC) begin
      sel_src = 1'b1;
    end else if (avs_address == `RSC_OFS_STRAP) begin
      sel_strap = 1'b1;
    end else if (avs_address == `RSC_OFS_ISTAT) begin
      sel_istat = 1'b1;
    end else if (avs_address == `RSC_OFS_IMASK) begin
      sel_imask = 1'b1;
    end
  end

  // bus handshake: one wait cycle, then the answer
  assign acc_ok = (avs_read | avs_write) & ack_ff;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
    end
  end

  // control register, restored by every flow
  always_ff @(posedge sys_clk) begin
    if (srst || state_ff != RSC_ST_RUN) begin
      ctrl_ff <= `RSC_CTRL_RST;
    end else if (acc_ok && avs_write && sel_ctrl) begin
      ctrl_ff <= avs_writedata[1:0];
    end
  end

  // last reset sources, all simultaneous ones recorded
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      src_ff <= rsc_src_t'(1 << `RSC_SRC_POR);
    end else if (flow_start) begin
      src_ff <= req;
    end
  end

  // sticky event status, one flop per source; set wins over read-clear, and a read
  // clears only the bits it returned, so an event landing in the wait cycle survives
  assign istat_clr = acc_ok & avs_read & sel_istat;
  for (genvar i = 0; i < `RSC_SRC_W; i++) begin : g_istat
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        istat_ff[i] <= 1'b0;
      end else if (flow_start && req[i]) begin
        istat_ff[i] <= 1'b1;
      end else if (istat_clr && rdata_ff[i]) begin
        istat_ff[i] <= 1'b0;
      end
    end
  end

  // interrupt mask, its own word after status
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      imask_ff <= '0;
    end else if (acc_ok && avs_write && sel_imask) begin
      imask_ff <= avs_writedata[`RSC_SRC_W-1:0];
    end
  end
  assign irq = |(istat_ff & imask_ff);

  // read data mux; unmapped reads give zero
  always_comb begin
    nxt_rdata = 32'h0;
    if (sel_ctrl) begin
      nxt_rdata = {30'h0, ctrl_ff};
    end else if (sel_src) begin
      nxt_rdata = {27'h0, src_ff};
    end else if (sel_strap) begin
      nxt_rdata = {27'h0, strap_ff};
    end else if (sel_istat) begin
      nxt_rdata = {27'h0, istat_ff};
    end else if (sel_imask) begin
      nxt_rdata = {27'h0, imask_ff};
    end
  end

  // read data, loaded during the wait cycle and held until the next read
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_ff <= 32'h0;
    end else if (avs_read && !ack_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign avs_readdata = rdata_ff;

endmodule

/* design/rsc_cfg.svh */
/*
  constants of the reset source controller: register offsets, field positions,
  reset values and release counts.
  assumes the input clock of the reset timing is the block clock sys_clk.
*/
// How it works
// - power-on reset resets everything, the pll state and core included, and drives the hard-reset line.
// - straps are sampled only by the power-on flow; hard and soft flows leave them alone.
// - the pll and clock synthesis reset follows power-on reset only.
// - an externally pulled-low hard-reset line launches the hard flow.
// - the hard-reset line is pulled low open-drain in power-on and hard flows, never in soft, never high.
// - a watchdog count at zero with its event enabled launches a hard flow.
// - a bus monitor count at zero with its event enabled launches a hard flow.
// - a tap extest, clamp or highz instruction launches a soft flow.
// - a readable register holds the sources of the most recent reset.
// - every flow resets the watchdog and bus monitor registers.
// - every flow resets clock stop control, halt request and halt acknowledge.
// - every flow resets the extended core and the peripherals.
// - on power-on release the two boot-mode bits, watchdog, byte-width and strobe straps are captured.
// - reset configuration comes from a host port or an i2c memory, selected by the straps.
// - the hard-reset line is released 521 input clocks after power-on release.
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH
// register byte offsets
`define RSC_OFS_CTRL 5'h00
`define RSC_OFS_SRC 5'h04
`define RSC_OFS_STRAP 5'h08
`define RSC_OFS_ISTAT 5'h0C
`define RSC_OFS_IMASK 5'h10
`define RSC_ADDR_W 5
// control fields and reset value
`define RSC_CTRL_WDOG_EN 0
`define RSC_CTRL_BMON_EN 1
`define RSC_CTRL_RST 2'h3
// source bit positions, shared by source, status and mask registers
`define RSC_SRC_POR 0
`define RSC_SRC_HARD_EXT 1
`define RSC_SRC_WDOG 2
`define RSC_SRC_BMON 3
`define RSC_SRC_TAP 4
`define RSC_SRC_W 5
// timing in input-clock periods, and the input clock to sys_clk ratio
`define RSC_POR_MIN_CLKS 16
`define RSC_POR_RELEASE_CLKS 521
`define RSC_CLKS_PER_INPUT_CLK 1
`define RSC_HARD_HOLD_CLKS 16
`define RSC_SOFT_HOLD_CLKS 8
`endif

/* design/rsc_pkg.sv */
/*
  types of the reset source controller.
  assumes rsc_cfg.svh is on the include path.
*/
`include "rsc_cfg.svh"
package rsc_pkg;
  // flow state, one-hot
  typedef enum logic [3:0] {
    RSC_ST_POR = 4'h1,
    RSC_ST_HARD = 4'h2,
    RSC_ST_SOFT = 4'h4,
    RSC_ST_RUN = 4'h8
  } rsc_state_e;
  // reset outputs to the device, all active high
  typedef struct packed {
    logic pll;
    logic core;
    logic periph;
    logic timer;
    logic clk_stop;
  } rsc_rst_s;
  // captured straps
  typedef struct packed {
    logic [1:0] boot_mode;
    logic watchdog_en;
    logic host_byte_width;
    logic host_strobe;
  } rsc_strap_s;
  // source vector
  typedef logic [`RSC_SRC_W-1:0] rsc_src_t;
endpackage

/* verif/rsc_reset_ctrl_monitor.sv */
/* port checker of the reset source controller.
   assumes a bind from the bench top. */
`timescale 1ns/1ps
module rsc_reset_ctrl_monitor #(
  parameter int POR_RELEASE = 521
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // pins and sources
  input wire logic power_on_reset_in_n,
  input wire logic hard_reset_line_in_n,
  input wire logic hard_reset_line_out,
  input wire logic hard_reset_line_oe,
  input wire logic watchdog_zero,
  input wire logic bus_monitor_zero,
  input wire logic tap_extest,
  input wire logic tap_clamp,
  input wire logic tap_highz,
  input wire logic [1:0] boot_mode_strap,
  input wire logic watchdog_enable_strap,
  input wire logic host_byte_width_strap,
  input wire logic host_strobe_strap,
  // outputs
  input wire rsc_pkg::rsc_rst_s rst_out,
  input wire logic soft_reset_internal,
  input wire rsc_pkg::rsc_strap_s strap_out,
  // bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  import rsc_pkg::*;
  localparam int POR_M1 = POR_RELEASE - 1;
  logic [4:0] strap_in;
  logic tap_any;
  logic run_quiet;
  // strap pins in strap_out order, tap commands merged
  assign strap_in = {boot_mode_strap, watchdog_enable_strap, host_byte_width_strap, host_strobe_strap};
  assign tap_any = tap_extest | tap_clamp | tap_highz;
  assign run_quiet = !rst_out.core && power_on_reset_in_n;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // line held from release to the last count, then let go
  sequence por_hold_s;
    hard_reset_line_oe ##POR_M1 hard_reset_line_oe;
  endsequence
  a_line_never_high: assert property (hard_reset_line_out == 1'b0) else $error("line driven high");
  a_soft_no_drive: assert property (soft_reset_internal |-> !hard_reset_line_oe) else $error("line in soft");
  a_por_resets_all: assert property (!power_on_reset_in_n |=> rst_out == 5'h1F && hard_reset_line_oe)
    else $error("por not full");
  a_por_release: assert property ($rose(power_on_reset_in_n) |-> por_hold_s ##1 !hard_reset_line_oe)
    else $error("line release count");
  a_strap_capture: assert property ($rose(power_on_reset_in_n) |=> strap_out == $past(strap_in))
    else $error("straps not captured");
  a_strap_kept: assert property (power_on_reset_in_n && !$rose(power_on_reset_in_n) |=> $stable(strap_out))
    else $error("straps changed");
  a_pll_por_only: assert property (power_on_reset_in_n && !rst_out.pll |=> !rst_out.pll)
    else $error("pll reset outside por");
  a_ext_hard: assert property (!hard_reset_line_in_n && !hard_reset_line_oe && run_quiet
    |=> hard_reset_line_oe && rst_out.core && !soft_reset_internal) else $error("no hard flow");
  a_tap_soft: assert property (tap_any && run_quiet && hard_reset_line_in_n && !watchdog_zero && !bus_monitor_zero
    |=> soft_reset_internal) else $error("no soft flow");
  a_soft_resets: assert property (soft_reset_internal |-> rst_out == 5'h0F) else $error("soft reset set");
  a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait");
endmodule

/* verif/rsc_board_model.sv */
/* board supervisor and another device on the shared hard-reset wire.
   assumes the wire has a pull-up. */
`timescale 1ns/1ps
module rsc_board_model (
  // clock
  input wire logic sys_clk,
  // wire drivers
  input wire logic other_pull,
  input wire logic hard_reset_line_oe,
  input wire logic hard_reset_line_out,
  // to the device
  output logic power_on_reset_in_n,
  output logic hard_reset_line_in_n
);
  // pull-up wire, low while any party pulls it
  assign hard_reset_line_in_n = !((hard_reset_line_oe && !hard_reset_line_out) || other_pull);
  initial power_on_reset_in_n = 1'b0;
  // supervisor never holds power-on for less than 16 clocks
  task automatic power_cycle(input int n);
    @(posedge sys_clk);
    power_on_reset_in_n <= 1'b0;
    repeat ((n < 16) ? 16 : n) @(posedge sys_clk);
    power_on_reset_in_n <= 1'b1;
  endtask
endmodule

/* verif/reset_source_controller_tb_top.sv */
/* bench of the reset source controller.
   assumes the board model and bound checker. */
`timescale 1ns/1ps
module reset_source_controller_tb_top;
  import rsc_pkg::*;
  localparam int P = 8;
  logic sys_clk, srst, power_on_reset_in_n, hard_reset_line_in_n, hard_reset_line_out, hard_reset_line_oe;
  logic soft_reset_internal, config_from_host, avs_read, avs_write, avs_waitrequest, irq;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [5:0] ev;
  logic [4:0] strap;
  rsc_rst_s rst_out;
  rsc_strap_s strap_out;
  int error_cnt, checked;
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  rsc_reset_ctrl #(.POR_RELEASE(P)) dut (.sys_clk, .srst, .power_on_reset_in_n, .hard_reset_line_in_n,
    .hard_reset_line_out, .hard_reset_line_oe, .watchdog_zero(ev[0]), .bus_monitor_zero(ev[1]),
    .tap_extest(ev[2]), .tap_clamp(ev[3]), .tap_highz(ev[4]), .boot_mode_strap(strap[4:3]),
    .watchdog_enable_strap(strap[2]), .host_byte_width_strap(strap[1]), .host_strobe_strap(strap[0]),
    .rst_out, .soft_reset_internal, .strap_out, .config_from_host, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .irq);
  rsc_board_model board (.sys_clk, .other_pull(ev[5]), .hard_reset_line_oe, .hard_reset_line_out,
    .power_on_reset_in_n, .hard_reset_line_in_n);
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // one avalon access, held until waitrequest is low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    chk(n < 20, "bus timeout");
    if (n >= 20) end_sim();
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // one-cycle source pulse, then run the flow out
  task automatic flow(input logic [5:0] e, input logic [4:0] src, input logic hard);
    int n;
    logic [31:0] q;
    @(posedge sys_clk);
    ev <= e;
    @(posedge sys_clk);
    ev <= 6'h00;
    #1 chk(hard_reset_line_oe === hard && soft_reset_internal === !hard && rst_out === 5'h0F, "flow");
    n = 0;
    while (rst_out.core !== 1'b0 && n < 40) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk(n < 40, "flow end");
    if (n >= 40) end_sim();
    bus(1'b0, 5'h04, 32'h0, q);
    chk(q === {27'h0, src}, "source");
  endtask
  task automatic t_por();
    int n;
    logic [31:0] q;
    board.power_cycle(20);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (hard_reset_line_oe === 1'b1 && n < 600);
    chk(n === P, "line release");
    chk(strap_out === 5'h16 && config_from_host === 1'b0, "straps");
    bus(1'b0, 5'h08, 32'h0, q);
    strap <= 5'h09;
    chk(q === 32'h16, "strap reg");
  endtask
  task automatic t_sources();
    flow(6'h20, 5'h02, 1'b1);
    flow(6'h01, 5'h04, 1'b1);
    flow(6'h02, 5'h08, 1'b1);
    for (int i = 2; i < 5; i++) flow(6'h01 << i, 5'h10, 1'b0);
    flow(6'h05, 5'h14, 1'b1);
    chk(strap_out === 5'h16, "straps kept");
  endtask
  task automatic t_irq();
    logic [31:0] q;
    bus(1'b1, 5'h10, 32'h1F, q);
    #1 chk(irq === 1'b1, "irq set");
    bus(1'b1, 5'h10, 32'h0, q);
    #1 chk(irq === 1'b0, "irq masked");
    bus(1'b1, 5'h00, 32'h0, q);
    ev <= 6'h01;
    @(posedge sys_clk);
    ev <= 6'h00;
    #1 chk(hard_reset_line_oe === 1'b0 && rst_out.core === 1'b0, "disabled watchdog");
    flow(6'h04, 5'h10, 1'b0);
    bus(1'b0, 5'h00, 32'h0, q);
    chk(q === 32'h3, "control restored");
    bus(1'b1, 5'h10, 32'h1F, q);
    bus(1'b0, 5'h0C, 32'h0, q);
    chk(q === 32'h1E, "status");
    #1 chk(irq === 1'b0, "irq cleared");
    bus(1'b0, 5'h01, 32'h0, q);
    chk(q === 32'h0, "unmapped");
  endtask
  // reset, then the scenarios
  initial begin
    srst = 1'b1;
    ev = 6'h00;
    strap = 5'h16;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    t_por();
    t_sources();
    t_irq();
    end_sim();
  end
endmodule
bind rsc_reset_ctrl rsc_reset_ctrl_monitor #(.POR_RELEASE(POR_RELEASE)) u_mon (.sys_clk, .srst,
  .power_on_reset_in_n, .hard_reset_line_in_n, .hard_reset_line_out, .hard_reset_line_oe, .watchdog_zero,
  .bus_monitor_zero, .tap_extest, .tap_clamp, .tap_highz, .boot_mode_strap, .watchdog_enable_strap,
  .host_byte_width_strap, .host_strobe_strap, .rst_out, .soft_reset_internal, .strap_out, .avs_read,
  .avs_write, .avs_waitrequest);
